// file: tb_ccd_timing_sequencer.sv
// Self-checking testbench of the CCD timing sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_ccd_timing_sequencer;
	import tcg_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h000;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic line_sync_in;
	logic frame_sync_in;
	logic trigger_in = 1'b0;
	logic [PIX_WIDTH-1:0] adc_data;
	logic [NUM_TERM-1:0] timing_pins;
	logic reference_sample_strobe_n;
	logic signal_sample_strobe_n;
	logic converter_clock;
	logic [PIX_WIDTH-1:0] pixel_out;
	logic slave_en = 1'b0;
	int bad_count = 0;
	int check_count = 0;
	int n;
	logic [31:0] v;
	logic [31:0] f0;
	always #25 aclk = ~aclk;
	tcg_timing_sequencer dut (.*);
	tcg_sensor_model u_sensor (.aclk, .converter_clock, .slave_en, .adc_data, .line_sync_in,
		.frame_sync_in);
	// ********************************
	// Checking and bus tasks
	// ********************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test;
		if (bad_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	function automatic logic [31:0] hword(input logic [2:0] op, input int term, input int step);
		return 32'(op) << OP_LSB | 32'(term) << TERM_LSB | 32'(step) << STEP_LSB;
	endfunction : hword
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			if (s[i])
				o[8*i+:8] = d[8*i+:8];
		return o;
	endfunction : merge
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
		input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
		do
			@(posedge aclk);
		while (!s_axi_bvalid);
		chk(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
			@(posedge aclk);
		while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		chk(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
	endtask : rd
	initial
	begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		finish_test();
	end
	initial
	begin
		void'($urandom(99));
		repeat (6) @(posedge aclk);
		chk(timing_pins, SIG_STANDBY);
		chk({reference_sample_strobe_n, signal_sample_strobe_n, converter_clock}, 3'b111);
		chk(pixel_out, '0);
		aresetn <= 1'b1;
		rd(OFS_CTRL, v);
		chk(v, CTRL_RESET);
		rd(OFS_POLARITY, v);
		chk(v, POLARITY_RESET);
		rd(12'h0FC, v, RESP_SLVERR);
		chk(v, 32'h0000_0000);
		wr(12'h0FC, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
		f0 = $urandom;
		wr(OFS_PIN_EN, f0);
		rd(OFS_PIN_EN, v);
		chk(v, f0);
		wr(OFS_POLARITY, f0, 4'h3);
		rd(OFS_POLARITY, v);
		chk(v, merge(POLARITY_RESET, f0, 4'h3));
		// Clamp and blanking enabled and idle high; blanking low for pixels 2 to 13.
		// Terminal 1 runs a repeating fast pattern from pixel 4 to 12; events count in line 1.
		wr(OFS_PIN_EN, 32'h0600_0002);
		wr(OFS_POLARITY, 32'h0600_0000);
		wr(OFS_HPROG, hword(HOP_TOGGLE, TERM_BLANK, 2));
		wr(OFS_HPROG + 12'h004, hword(HOP_TOGGLE, TERM_BLANK, 14));
		wr(OFS_HPROG + 12'h008, hword(HOP_LINE_END, 0, 15));
		wr(OFS_HPROG + 12'h00C, hword(HOP_FAST_START, 0, 4));
		wr(OFS_HPROG + 12'h010, hword(HOP_FAST_STOP, 0, 12));
		wr(OFS_FPROG, 32'h0004_2001);
		wr(OFS_VPROG, 32'(VOP_INIT) << VOP_LSB);
		wr(OFS_VPROG + 12'h004, 32'(VOP_FRAME_END) << VOP_LSB | 32'h0000_0002);
		wr(OFS_VPROG + 12'h008, 32'(VOP_EVENT_START) << VOP_LSB);
		wr(OFS_VPROG + 12'h00C, 32'(VOP_EVENT_STOP) << VOP_LSB | 32'h0000_0001);
		wr(OFS_CTRL, 32'h0000_0001);
		repeat (200) @(posedge aclk);
		chk(timing_pins[TERM_BLACK_CLAMP], 1'b1);
		chk(timing_pins[TERM_DUMMY_CLAMP], SIG_DEFAULT[TERM_DUMMY_CLAMP]);
		n = 0;
		f0 = 32'h0000_0000;
		v[0] = timing_pins[1];
		repeat (64)
		begin
			@(posedge aclk);
			n += int'(pixel_out[15] === 1'b1);
			f0 += 32'(timing_pins[1] !== v[0]);
			v[0] = timing_pins[1];
		end
		chk(n > 0, 1'b1);
		chk(f0, 32'h0000_0008);
		n = 0;
		repeat (8)
		begin
			repeat ($urandom_range(1, 20)) @(posedge aclk);
			rd(OFS_COUNT, v);
			chk(v[12:0] <= 15, 1'b1);
			chk(v[27:16] <= 2, 1'b1);
			rd(OFS_FRAME, f0);
			chk(f0[31:16] <= 1, 1'b1);
			n += int'(f0[31:16]);
		end
		chk(n > 0, 1'b1);
		rd(OFS_FRAME, f0);
		repeat (300) @(posedge aclk);
		rd(OFS_FRAME, v);
		chk(v[15:0] != f0[15:0], 1'b1);
		wr(OFS_CMD, 32'h0000_0001);
		rd(OFS_COUNT, v);
		chk(v[31], 1'b0);
		rd(OFS_FRAME, v);
		chk(v[15:0] >= 2, 1'b1);
		wr(OFS_CTRL, 32'h0000_0005);
		wr(OFS_CMD, 32'h0000_0001);
		rd(OFS_FRAME, v);
		chk(v[15:0] <= 1, 1'b1);
		wr(OFS_CTRL, 32'h0000_0009);
		repeat ($urandom_range(20, 40)) @(posedge aclk);
		wr(OFS_CMD, 32'h0000_0001);
		rd(OFS_COUNT, v);
		chk(v[27:16] == 0 && v[12:0] <= 6, 1'b1);
		wr(OFS_CTRL, 32'h0000_0011);
		trigger_in <= 1'b1;
		repeat (4) @(posedge aclk);
		trigger_in <= 1'b0;
		repeat (8) @(posedge aclk);
		rd(OFS_COUNT, v);
		chk(v[31], 1'b1);
		repeat (20) @(posedge aclk);
		rd(OFS_COUNT, f0);
		chk(f0, v);
		wr(OFS_CTRL, 32'h0000_0000);
		repeat (4) @(posedge aclk);
		chk(timing_pins, SIG_STANDBY);
		chk({reference_sample_strobe_n, signal_sample_strobe_n, converter_clock}, 3'b111);
		rd(OFS_COUNT, v);
		chk(v, 32'h0000_0000);
		// Without a line end only the external line sync can keep the pixel count short.
		wr(OFS_HPROG + 12'h008, PROG_RESET);
		slave_en <= 1'b1;
		wr(OFS_CTRL, 32'h0000_0003);
		repeat (300) @(posedge aclk);
		repeat (4)
		begin
			repeat ($urandom_range(1, 40)) @(posedge aclk);
			rd(OFS_COUNT, v);
			chk(v[12:0] <= 30, 1'b1);
		end
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		chk(timing_pins, SIG_STANDBY);
		finish_test();
	end
endmodule : tb_ccd_timing_sequencer
`default_nettype wire

// file: tcg_pkg.sv
// Package with register map, program field layout and constants of the CCD timing sequencer.
package tcg_pkg;

	// ********************************
	// Sizes
	// ********************************
	localparam int H_WIDTH = 13;
	localparam int V_WIDTH = 12;
	localparam int FRAME_WIDTH = 16;
	localparam int HPROG_DEPTH = 8;
	localparam int VPROG_DEPTH = 8;
	localparam int FPROG_DEPTH = 4;
	localparam int NUM_TERM = 32;
	localparam int PIX_WIDTH = 16;
	// Converter pipeline latency in converter clocks.
	localparam int ADC_LATENCY = 4;

	// ********************************
	// Register byte offsets
	// ********************************
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_PIN_EN = 12'h004;
	localparam logic [11:0] OFS_POLARITY = 12'h008;
	localparam logic [11:0] OFS_COUNT = 12'h00C;
	localparam logic [11:0] OFS_FRAME = 12'h010;
	localparam logic [11:0] OFS_CMD = 12'h014;
	localparam logic [11:0] OFS_HPROG = 12'h040;
	localparam logic [11:0] OFS_VPROG = 12'h060;
	localparam logic [11:0] OFS_FPROG = 12'h080;

	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] PIN_EN_RESET = 32'h0000_0000;
	localparam logic [31:0] POLARITY_RESET = 32'h0000_0000;
	localparam logic [31:0] PROG_RESET = 32'h0000_0000;

	localparam int CTRL_RUN = 0;
	localparam int CTRL_SLAVE = 1;
	localparam int CTRL_EXTERNAL_EVENT_UNIT_FRAME_RESET = 2;
	localparam int CTRL_EXTERNAL_EVENT_UNIT_FRAME_LOAD = 3;
	localparam int CTRL_EXTERNAL_EVENT_UNIT_STOP = 4;
	localparam int CMD_TRIGGER = 0;

	// ********************************
	// Program word layout
	// ********************************
	localparam int STEP_LSB = 0;
	localparam int TERM_LSB = 13;
	localparam int OP_LSB = 18;
	localparam int HBANK_BIT = 21;
	localparam int FREPEAT_BIT = 18;
	localparam int LINE_LSB = 0;
	localparam int VOP_LSB = 12;
	localparam int VBANK_BIT = 15;

	localparam logic [2:0] HOP_TOGGLE = 3'h1;
	localparam logic [2:0] HOP_LINE_END = 3'h2;
	localparam logic [2:0] HOP_FAST_START = 3'h3;
	localparam logic [2:0] HOP_FAST_STOP = 3'h4;

	localparam logic [2:0] VOP_FRAME_CLEAR = 3'h1;
	localparam logic [2:0] VOP_INIT = 3'h2;
	localparam logic [2:0] VOP_EVENT_START = 3'h3;
	localparam logic [2:0] VOP_EVENT_STOP = 3'h4;
	localparam logic [2:0] VOP_FRAME_END = 3'h5;
	localparam logic [2:0] VOP_CALL = 3'h6;

	// ********************************
	// Terminals and levels
	// ********************************
	localparam int TERM_DUMMY_CLAMP = 24;
	localparam int TERM_BLACK_CLAMP = 25;
	localparam int TERM_BLANK = 26;
	localparam int TERM_HBLANK = 27;
	localparam int TERM_HORIZONTAL_DIVIDE = 28;
	localparam int TERM_FRAME_SYNC = 29;
	localparam int TERM_LINE_SYNC = 30;
	localparam logic [31:0] SIG_DEFAULT = 32'h003F_3FFE;
	localparam logic [31:0] SIG_STANDBY = 32'h033F_3FFE;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : tcg_pkg

// file: tcg_sensor_model.sv
// Behavioural CCD sensor: pixel words on the converter clock and slave syncs.
`timescale 1ns/1ps
`default_nettype none
module tcg_sensor_model
	import tcg_pkg::*;
(
	input wire logic aclk,
	input wire logic converter_clock,
	input wire logic slave_en,
	output logic [PIX_WIDTH-1:0] adc_data,
	output logic line_sync_in,
	output logic frame_sync_in
);
	int cnt = 0;
	int lines = 0;
	initial
	begin
		adc_data = 16'h8001;
		line_sync_in = 1'b1;
		frame_sync_in = 1'b1;
	end
	// Bit 15 is always set, so a zero word can only come from blanking or from the pipeline emptied by reset or standby.
	always @(posedge converter_clock)
		adc_data <= 16'h8000 | 16'($urandom);
	// Syncs idle high; the falling edge marks a line every 50 cycles, a frame every 8 lines.
	always @(posedge aclk)
	begin
		cnt <= (slave_en && cnt < 49) ? cnt + 1 : 0;
		line_sync_in <= !(slave_en && cnt >= 47);
		if (slave_en && cnt == 49)
			lines <= (lines + 1) % 8;
		frame_sync_in <= !(slave_en && lines == 0 && cnt >= 47);
	end
endmodule : tcg_sensor_model
`default_nettype wire

// file: tcg_seq_props.sv
// Concurrent assertions on the ports of the CCD timing sequencer.
`timescale 1ns/1ps
`default_nettype none
module tcg_seq_props
	import tcg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_TERM-1:0] timing_pins,
	input wire logic reference_sample_strobe_n,
	input wire logic signal_sample_strobe_n,
	input wire logic converter_clock,
	input wire logic [PIX_WIDTH-1:0] pixel_out
);
	default clocking cb @(posedge aclk);
	endclocking
	// Saturating count of blanked cycles; long enough covers the converter pipeline.
	logic [4:0] blank_cnt;
	always_ff @(posedge aclk)
	begin
		if (!aresetn || timing_pins[TERM_BLANK])
			blank_cnt <= 5'h00;
		else if (blank_cnt != 5'h1F)
			blank_cnt <= blank_cnt + 5'h01;
	end
	property p_rst_standby;
		!aresetn [*3] |-> timing_pins == SIG_STANDBY;
	endproperty
	a_rst_standby: assert property (p_rst_standby) else $error("pins off standby level");
	property p_rst_strobes;
		!aresetn [*2] |-> reference_sample_strobe_n && signal_sample_strobe_n && converter_clock;
	endproperty
	a_rst_strobes: assert property (p_rst_strobes) else $error("strobes not masked high");
	property p_cc_square;
		disable iff (!aresetn) !converter_clock |=> converter_clock;
	endproperty
	a_cc_square: assert property (p_cc_square) else $error("converter clock stuck low");
	property p_out_sync;
		disable iff (!aresetn) $changed(pixel_out) |-> $changed(converter_clock);
	endproperty
	a_out_sync: assert property (p_out_sync) else $error("output word off converter clock");
	property p_blank_zero;
		disable iff (!aresetn) $changed(pixel_out) && blank_cnt >= 5'h0C |-> pixel_out == '0;
	endproperty
	a_blank_zero: assert property (p_blank_zero) else $error("blanked word not zero");
	property p_b_done;
		disable iff (!aresetn) s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write response repeated");
	property p_r_done;
		disable iff (!aresetn) s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_done: assert property (p_r_done) else $error("read response repeated");
	property p_ar_block;
		disable iff (!aresetn) s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
endmodule : tcg_seq_props
bind tcg_timing_sequencer tcg_seq_props u_props (.aclk, .aresetn, .s_axi_arready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_rvalid, .s_axi_rready, .timing_pins, .reference_sample_strobe_n,
	.signal_sample_strobe_n, .converter_clock, .pixel_out);
`default_nettype wire

// file: tcg_signal_cell.sv
// One generated timing signal with toggle state, initial polarity and pin enable.
`timescale 1ns/1ps
`default_nettype none
module tcg_signal_cell
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic toggle,
	input wire logic load_init,
	input wire logic init_level,
	input wire logic hold,
	input wire logic hold_level,
	input wire logic reset_level,
	output logic pin
);
	logic state;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state <= 1'b0;
		else if (load_init)
			state <= init_level;
		else if (toggle)
			state <= ~state;
	end

	// The pin shows the reset level in reset, the hold level while held, and the programmed state otherwise.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pin <= reset_level;
		else if (hold)
			pin <= hold_level;
		else
			pin <= load_init ? init_level : (toggle ? ~state : state);
	end

endmodule : tcg_signal_cell
`default_nettype wire

// file: tcg_sync_edge.sv
// Two-flop synchroniser with one-cycle edge pulse.
`timescale 1ns/1ps
`default_nettype none
module tcg_sync_edge
#(
	parameter bit FALLING = 1'b1
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic async_in,
	output logic edge_pulse
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			edge_pulse <= 1'b0;
		end
		else
		begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
			edge_pulse <= FALLING ? (s3 & ~s2) : (s2 & ~s3);
		end
	end
endmodule : tcg_sync_edge
`default_nettype wire

// file: tcg_timing_sequencer.sv
// CCD timing sequencer: counters, programs, output control, converter strobes and AXI4-Lite slave.
//
// Summary of operation
// - 13-bit pixel and 12-bit line counters
// - Sync is generated (master) or taken (slave)
// - Horizontal program toggles signals at pixel steps
// - Pixel counter restarts on sync, line end, trigger
// - Line sequencer advances per line, selects program
// - Frame counter counts frames, clearable two ways
// - Fast transfer counter started by horizontal program
// - Fast pattern repeats until stop command
// - Event counter counts only between start/stop
// - Three trigger actions, each register enabled
// - Per-signal pin enable and initial polarity
// - Sampler runs on reference and signal strobes
// - Pixel output words change on converter clock
// - Blanking zeroes output after pipeline latency
// - Clamp pulses come from programmed pixel steps
// - Standby masks strobes, converter clock, clamps high
// - Clamp, blanking, blank, divide are active low
// - Run bit resets to standby, host starts
// - Outputs disabled at reset, polarity by initialize
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tcg_timing_sequencer
	import tcg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic line_sync_in,
	input wire logic frame_sync_in,
	input wire logic trigger_in,
	input wire logic [PIX_WIDTH-1:0] adc_data,
	output logic [NUM_TERM-1:0] timing_pins,
	output logic reference_sample_strobe_n,
	output logic signal_sample_strobe_n,
	output logic converter_clock,
	output logic [PIX_WIDTH-1:0] pixel_out
);
	// ********************************
	// Registers
	// ********************************
	logic [31:0] ctrl;
	logic [31:0] pin_en;
	logic [31:0] polarity;
	logic [31:0] hprog [HPROG_DEPTH];
	logic [31:0] vprog [VPROG_DEPTH];
	logic [31:0] fprog [FPROG_DEPTH];
	logic sw_trigger;
	logic halted;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_go;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				res[8*b +: 8] = nw[8*b +: 8];
		return res;
	endfunction : merge

	logic wr_hprog;
	logic wr_vprog;
	logic wr_fprog;
	logic wr_known;
	always_comb
	begin
		wr_hprog = wr_addr[11:5] == OFS_HPROG[11:5];
		wr_vprog = wr_addr[11:5] == OFS_VPROG[11:5];
		wr_fprog = wr_addr[11:4] == OFS_FPROG[11:4];
		wr_known = wr_hprog || wr_vprog || wr_fprog || wr_addr == OFS_CTRL
			|| wr_addr == OFS_PIN_EN || wr_addr == OFS_POLARITY || wr_addr == OFS_CMD
			|| wr_addr == OFS_COUNT || wr_addr == OFS_FRAME;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= CTRL_RESET;
			pin_en <= PIN_EN_RESET;
			polarity <= POLARITY_RESET;
			sw_trigger <= 1'b0;
			for (int i = 0; i < HPROG_DEPTH; i++)
				hprog[i] <= PROG_RESET;
			for (int i = 0; i < VPROG_DEPTH; i++)
				vprog[i] <= PROG_RESET;
			for (int i = 0; i < FPROG_DEPTH; i++)
				fprog[i] <= PROG_RESET;
		end
		else
		begin
			sw_trigger <= wr_go && wr_addr == OFS_CMD && wr_strb[0] && wr_data[CMD_TRIGGER];
			if (wr_go)
			begin
				if (wr_addr == OFS_CTRL)
					ctrl <= merge(ctrl, wr_data, wr_strb);
				if (wr_addr == OFS_PIN_EN)
					pin_en <= merge(pin_en, wr_data, wr_strb);
				if (wr_addr == OFS_POLARITY)
					polarity <= merge(polarity, wr_data, wr_strb);
				if (wr_hprog)
					hprog[wr_addr[4:2]] <= merge(hprog[wr_addr[4:2]], wr_data, wr_strb);
				if (wr_vprog)
					vprog[wr_addr[4:2]] <= merge(vprog[wr_addr[4:2]], wr_data, wr_strb);
				if (wr_fprog)
					fprog[wr_addr[3:2]] <= merge(fprog[wr_addr[3:2]], wr_data, wr_strb);
			end
		end
	end

	// ********************************
	// AXI4-Lite write channel
	// ********************************
	// Address and data are taken in either order; the write lands when both are held.
	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			wr_addr <= 12'h000;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				wr_addr <= {s_axi_awaddr[11:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ********************************
	// Counters and program engines
	// ********************************
	logic phase;
	logic tick;
	logic standby;
	logic slave;
	logic [H_WIDTH-1:0] h_count;
	logic [V_WIDTH-1:0] v_count;
	logic [FRAME_WIDTH-1:0] frame_count;
	logic [H_WIDTH-1:0] f_count;
	logic [15:0] event_count;
	logic fast_run;
	logic event_open;
	logic h_bank;
	logic line_evt;
	logic frame_evt;
	logic external_event_unit_evt;
	logic pin_external_event_unit;

	assign standby = !ctrl[CTRL_RUN];
	assign slave = ctrl[CTRL_SLAVE];
	assign external_event_unit_evt = pin_external_event_unit || sw_trigger;

	tcg_sync_edge #(.FALLING(1'b1)) u_line_sync (.aclk(aclk), .aresetn(aresetn),
		.async_in(line_sync_in), .edge_pulse(line_evt));
	tcg_sync_edge #(.FALLING(1'b1)) u_frame_sync (.aclk(aclk), .aresetn(aresetn),
		.async_in(frame_sync_in), .edge_pulse(frame_evt));
	tcg_sync_edge #(.FALLING(1'b0)) u_trigger (.aclk(aclk), .aresetn(aresetn),
		.async_in(trigger_in), .edge_pulse(pin_external_event_unit));

	// Pixel master clock is aclk/2; tick marks the converter clock falling edge.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || standby)
			phase <= 1'b0;
		else
			phase <= ~phase;
	end
	assign tick = phase && !halted;

	logic [NUM_TERM-1:0] toggles;
	logic line_end;
	logic fast_start;
	logic fast_stop;
	logic fast_repeat;
	always_comb
	begin
		toggles = '0;
		line_end = 1'b0;
		fast_start = 1'b0;
		fast_stop = 1'b0;
		fast_repeat = 1'b0;
		for (int i = 0; i < HPROG_DEPTH; i++)
			if (tick && hprog[i][HBANK_BIT] == h_bank
				&& hprog[i][STEP_LSB +: H_WIDTH] == h_count)
				case (hprog[i][OP_LSB +: 3])
					HOP_TOGGLE: toggles[hprog[i][TERM_LSB +: 5]] = 1'b1;
					HOP_LINE_END: line_end = 1'b1;
					HOP_FAST_START: fast_start = 1'b1;
					HOP_FAST_STOP: fast_stop = 1'b1;
					default: ;
				endcase
		for (int i = 0; i < FPROG_DEPTH; i++)
			if (tick && fast_run && fprog[i][STEP_LSB +: H_WIDTH] == f_count)
			begin
				toggles[fprog[i][TERM_LSB +: 5]] = 1'b1;
				if (fprog[i][FREPEAT_BIT])
					fast_repeat = 1'b1;
			end
	end

	// Several restart sources in one cycle give one restart to zero.
	logic h_restart;
	assign h_restart = !standby && ((slave && line_evt) || line_end
		|| (external_event_unit_evt && ctrl[CTRL_EXTERNAL_EVENT_UNIT_FRAME_LOAD]));

	logic frame_clear;
	logic load_init;
	logic ev_start;
	logic ev_stop;
	logic frame_end;
	logic call;
	logic call_bank;
	always_comb
	begin
		frame_clear = 1'b0;
		load_init = 1'b0;
		ev_start = 1'b0;
		ev_stop = 1'b0;
		frame_end = 1'b0;
		call = 1'b0;
		call_bank = 1'b0;
		for (int i = 0; i < VPROG_DEPTH; i++)
			if (h_restart && vprog[i][LINE_LSB +: V_WIDTH] == v_count)
				case (vprog[i][VOP_LSB +: 3])
					VOP_FRAME_CLEAR: frame_clear = 1'b1;
					VOP_INIT: load_init = 1'b1;
					VOP_EVENT_START: ev_start = 1'b1;
					VOP_EVENT_STOP: ev_stop = 1'b1;
					VOP_FRAME_END: frame_end = 1'b1;
					VOP_CALL:
					begin
						call = 1'b1;
						call_bank = vprog[i][VBANK_BIT];
					end
					default: ;
				endcase
	end

	logic v_restart;
	assign v_restart = !standby && ((slave && frame_evt) || frame_end
		|| (external_event_unit_evt && ctrl[CTRL_EXTERNAL_EVENT_UNIT_FRAME_LOAD]));

	always_ff @(posedge aclk)
	begin
		if (!aresetn || standby)
			h_count <= '0;
		else if (h_restart)
			h_count <= '0;
		else if (tick)
			h_count <= h_count + 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || standby)
		begin
			v_count <= '0;
			h_bank <= 1'b0;
		end
		else
		begin
			if (v_restart)
				v_count <= '0;
			else if (h_restart)
				v_count <= v_count + 1'b1;
			if (call)
				h_bank <= call_bank;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			frame_count <= '0;
		else if (frame_clear || (external_event_unit_evt && ctrl[CTRL_EXTERNAL_EVENT_UNIT_FRAME_RESET]))
			frame_count <= '0;
		else if (v_restart)
			frame_count <= frame_count + 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || standby)
		begin
			fast_run <= 1'b0;
			f_count <= '0;
		end
		else if (fast_stop)
			fast_run <= 1'b0;
		else if (fast_start)
		begin
			fast_run <= 1'b1;
			f_count <= '0;
		end
		else if (fast_run && tick)
			f_count <= fast_repeat ? '0 : f_count + 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || standby)
		begin
			event_open <= 1'b0;
			event_count <= 16'h0000;
		end
		else
		begin
			if (ev_start)
			begin
				event_open <= 1'b1;
				event_count <= 16'h0000;
			end
			else if (ev_stop)
				event_open <= 1'b0;
			if (event_open && fast_start && !ev_start)
				event_count <= event_count + 1'b1;
		end
	end

	// A stop trigger freezes timing until software rewrites the control word.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			halted <= 1'b0;
		else if (external_event_unit_evt && ctrl[CTRL_EXTERNAL_EVENT_UNIT_STOP] && !standby)
			halted <= 1'b1;
		else if (wr_go && wr_addr == OFS_CTRL)
			halted <= 1'b0;
	end

	// ********************************
	// Output controller
	// ********************************
	logic [NUM_TERM-1:0] sync_hold;
	assign sync_hold = slave ? (32'h0000_0001 << TERM_LINE_SYNC) | (32'h0000_0001 << TERM_FRAME_SYNC)
		: 32'h0000_0000;

	for (genvar t = 0; t < NUM_TERM; t++)
	begin : g_cell
		tcg_signal_cell u_cell (
			.aclk(aclk),
			.aresetn(aresetn),
			.toggle(toggles[t]),
			.load_init(load_init),
			.init_level(polarity[t]),
			.hold(standby || !pin_en[t] || sync_hold[t]),
			.hold_level(standby ? SIG_STANDBY[t] : SIG_DEFAULT[t]),
			.reset_level(SIG_STANDBY[t]),
			.pin(timing_pins[t])
		);
	end

	// ********************************
	// Sampler strobes and converter path
	// ********************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn || standby)
		begin
			reference_sample_strobe_n <= 1'b1;
			signal_sample_strobe_n <= 1'b1;
			converter_clock <= 1'b1;
		end
		else
		begin
			reference_sample_strobe_n <= phase;
			signal_sample_strobe_n <= ~phase;
			converter_clock <= ~phase;
		end
	end

	// Blanking rides the pipeline with the data; standby empties it so no stale word leaves.
	logic [PIX_WIDTH-1:0] data_pipe [ADC_LATENCY];
	logic blank_pipe [ADC_LATENCY];
	always_ff @(posedge aclk)
	begin
		if (!aresetn || standby)
		begin
			for (int i = 0; i < ADC_LATENCY; i++)
			begin
				data_pipe[i] <= '0;
				blank_pipe[i] <= 1'b0;
			end
			pixel_out <= '0;
		end
		else if (tick && !standby)
		begin
			data_pipe[0] <= adc_data;
			blank_pipe[0] <= !timing_pins[TERM_BLANK];
			for (int i = 1; i < ADC_LATENCY; i++)
			begin
				data_pipe[i] <= data_pipe[i-1];
				blank_pipe[i] <= blank_pipe[i-1];
			end
			pixel_out <= blank_pipe[ADC_LATENCY-1] ? '0 : data_pipe[ADC_LATENCY-1];
		end
	end

	// ********************************
	// AXI4-Lite read channel
	// ********************************
	logic [31:0] rd_word;
	logic rd_ok;
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		if (s_axi_araddr[11:5] == OFS_HPROG[11:5])
			rd_word = hprog[s_axi_araddr[4:2]];
		else if (s_axi_araddr[11:5] == OFS_VPROG[11:5])
			rd_word = vprog[s_axi_araddr[4:2]];
		else if (s_axi_araddr[11:4] == OFS_FPROG[11:4])
			rd_word = fprog[s_axi_araddr[3:2]];
		else
			case ({s_axi_araddr[11:2], 2'b00})
				OFS_CTRL: rd_word = ctrl;
				OFS_PIN_EN: rd_word = pin_en;
				OFS_POLARITY: rd_word = polarity;
				OFS_COUNT: rd_word = {halted, 3'h0, v_count, 3'h0, h_count};
				OFS_FRAME: rd_word = {event_count, frame_count};
				OFS_CMD: rd_word = 32'h0000_0000;
				default: rd_ok = 1'b0;
			endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule : tcg_timing_sequencer
`default_nettype wire
